// file: shared/sibacc_map.svh
// offsets, field positions and reset values of the indexed block access slave
`ifndef SIBACC_MAP_SVH
`define SIBACC_MAP_SVH
`define SIBACC_ADDR_W        8'hD2
`define SIBACC_ADDR_R        8'hD3
`define SIBACC_BYTES         16
`define SIBACC_IDX_W         4
`define SIBACC_BC_IDX        4'h6
`define SIBACC_BC_LSB        0
`define SIBACC_BC_MSB        5
`define SIBACC_BC_RESET      8'h08
`define SIBACC_CFG_RESET     8'h00
`endif

// file: shared/sibacc_pkg.sv
// types of the indexed block access slave
package sibacc_pkg;
    typedef enum {
        SIBACC_IDLE,
        SIBACC_ADDR,
        SIBACC_INDEX,
        SIBACC_COUNT,
        SIBACC_WDATA,
        SIBACC_ACK,
        SIBACC_TXB,
        SIBACC_RACK,
        SIBACC_IGNORE
    } sibacc_state_e;
endpackage

// file: src/sibacc_mem.sv
// configuration byte store, registered read port
`timescale 1ns/10ps
`default_nettype none
`include "sibacc_map.svh"
module sibacc_mem #(
    parameter int DEPTH = `SIBACC_BYTES,
    parameter int AW    = `SIBACC_IDX_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem_reg [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_byte
            always_ff @(posedge clk)
            begin
                if (rst)
                    mem_reg[g] <= (g == `SIBACC_BC_IDX) ? `SIBACC_BC_RESET : `SIBACC_CFG_RESET;
                else if (we && waddr == AW'(g))
                    mem_reg[g] <= wdata;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else
            rdata <= mem_reg[raddr];
    end
endmodule // sibacc_mem
`default_nettype wire

// file: src/sibacc_slave.sv
// smbus indexed block access slave, oversampled on the system clock
//
// Summary of operation
// - ack write address, index and count bytes
// - ack each data byte, store consecutively
// - first read byte is the byte count
// - then consecutive bytes, count-limited
// - host nacks last; device releases data line
// - six-bit read count, defaults to eight
`timescale 1ns/10ps
`default_nettype none
`include "sibacc_map.svh"
module sibacc_slave #(
    parameter int        AW     = `SIBACC_IDX_W,
    parameter logic [7:0] ADDR_W = `SIBACC_ADDR_W
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic SMB_CLK_I,
    input  wire logic SMB_DAT_I,
    output logic      SMB_DAT_O,
    output logic      SMB_DAT_OE_N
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], SMB_CLK_I};
            sda_sync_reg <= {sda_sync_reg[0], SMB_DAT_I};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl        = scl_sync_reg[1];
    assign sda        = sda_sync_reg[1];
    assign scl_rise   = scl & ~scl_d_reg;
    assign scl_fall   = ~scl & scl_d_reg;
    // data edges only count while the clock is high and stable
    assign start_cond = scl & scl_d_reg & sda_d_reg & ~sda;
    assign stop_cond  = scl & scl_d_reg & ~sda_d_reg & sda;

    ////////////////////////////////////////////////////////////////////////////
    // byte engine
    sibacc_pkg::sibacc_state_e state_reg;
    sibacc_pkg::sibacc_state_e after_ack_reg;
    logic [7:0]    shift_reg;
    logic [3:0]    bit_cnt_reg;
    logic [AW-1:0] index_reg;
    logic [5:0]    left_reg;
    logic          drive_low_reg;
    logic          tx_bit_reg;
    logic          tx_mode_reg;
    logic          mem_we_reg;
    logic [7:0]    mem_wdata_reg;
    logic [AW-1:0] mem_waddr_reg;
    logic [7:0]    mem_rdata;
    logic [7:0]    bc_byte_reg;

    logic [7:0] rx_byte;
    assign rx_byte = {shift_reg[6:0], sda};

    sibacc_mem #(
        .DEPTH (`SIBACC_BYTES),
        .AW    (AW)
    ) u_mem (
        .clk   (CLK),
        .rst   (RST),
        .we    (mem_we_reg),
        .waddr (mem_waddr_reg),
        .wdata (mem_wdata_reg),
        .raddr (index_reg),
        .rdata (mem_rdata)
    );

    // shadow of the count byte so the count can be sent without a memory turn
    always_ff @(posedge CLK)
    begin
        if (RST)
            bc_byte_reg <= `SIBACC_BC_RESET;
        else if (mem_we_reg && mem_waddr_reg == AW'(`SIBACC_BC_IDX))
            bc_byte_reg <= mem_wdata_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg      <= sibacc_pkg::SIBACC_IDLE;
            after_ack_reg  <= sibacc_pkg::SIBACC_IDLE;
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 4'h0;
            index_reg      <= '0;
            left_reg       <= 6'h00;
            drive_low_reg  <= 1'b0;
            tx_bit_reg     <= 1'b1;
            tx_mode_reg    <= 1'b0;
            mem_we_reg     <= 1'b0;
            mem_wdata_reg  <= 8'h00;
            mem_waddr_reg  <= '0;
        end
        else
        begin
            mem_we_reg <= 1'b0;
            if (stop_cond)
            begin
                state_reg     <= sibacc_pkg::SIBACC_IDLE;
                drive_low_reg <= 1'b0;
                tx_mode_reg   <= 1'b0;
            end
            else if (start_cond)
            begin
                state_reg     <= sibacc_pkg::SIBACC_ADDR;
                bit_cnt_reg   <= 4'h0;
                drive_low_reg <= 1'b0;
                tx_mode_reg   <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    sibacc_pkg::SIBACC_ADDR,
                    sibacc_pkg::SIBACC_INDEX,
                    sibacc_pkg::SIBACC_COUNT,
                    sibacc_pkg::SIBACC_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_fall && bit_cnt_reg == 4'h8)
                        begin
                            bit_cnt_reg   <= 4'h0;
                            drive_low_reg <= 1'b1;
                            state_reg     <= sibacc_pkg::SIBACC_ACK;
                            case (state_reg)
                                sibacc_pkg::SIBACC_ADDR:
                                begin
                                    if (shift_reg[7:1] != ADDR_W[7:1])
                                    begin
                                        // not our address: stay off the line
                                        drive_low_reg <= 1'b0;
                                        state_reg     <= sibacc_pkg::SIBACC_IGNORE;
                                    end
                                    else if (shift_reg[0])
                                    begin
                                        tx_mode_reg    <= 1'b1;
                                        left_reg       <= bc_byte_reg[`SIBACC_BC_MSB:`SIBACC_BC_LSB];
                                        after_ack_reg  <= sibacc_pkg::SIBACC_TXB;
                                    end
                                    else
                                        after_ack_reg <= sibacc_pkg::SIBACC_INDEX;
                                end
                                sibacc_pkg::SIBACC_INDEX:
                                begin
                                    index_reg     <= shift_reg[AW-1:0];
                                    after_ack_reg <= sibacc_pkg::SIBACC_COUNT;
                                end
                                sibacc_pkg::SIBACC_COUNT:
                                    after_ack_reg <= sibacc_pkg::SIBACC_WDATA;
                                default:
                                begin
                                    mem_we_reg    <= 1'b1;
                                    mem_waddr_reg <= index_reg;
                                    mem_wdata_reg <= shift_reg;
                                    index_reg     <= index_reg + AW'(1);
                                    after_ack_reg <= sibacc_pkg::SIBACC_WDATA;
                                end
                            endcase
                        end
                    end
                    sibacc_pkg::SIBACC_ACK:
                    begin
                        if (scl_fall)
                        begin
                            drive_low_reg <= 1'b0;
                            state_reg     <= after_ack_reg;
                            if (after_ack_reg == sibacc_pkg::SIBACC_TXB)
                            begin
                                shift_reg   <= bc_byte_reg;
                                tx_bit_reg  <= bc_byte_reg[7];
                                bit_cnt_reg <= 4'h1;
                            end
                        end
                    end
                    sibacc_pkg::SIBACC_TXB:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_reg == 4'h8)
                            begin
                                tx_bit_reg <= 1'b1; // let the host answer
                                state_reg  <= sibacc_pkg::SIBACC_RACK;
                            end
                            else
                            begin
                                tx_bit_reg  <= shift_reg[3'(7 - bit_cnt_reg)];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    sibacc_pkg::SIBACC_RACK:
                    begin
                        if (scl_rise)
                            shift_reg[0] <= sda; // ack level from the host
                        if (scl_fall)
                        begin
                            // nack or count spent ends the burst
                            // left counts data bytes still owed; zero after the count byte sends none
                            if (shift_reg[0] || left_reg == 6'h00)
                            begin
                                tx_mode_reg <= 1'b0;
                                state_reg   <= sibacc_pkg::SIBACC_IGNORE;
                            end
                            else
                            begin
                                // memory read of index_reg is already settled
                                shift_reg   <= mem_rdata;
                                tx_bit_reg  <= mem_rdata[7];
                                bit_cnt_reg <= 4'h1;
                                index_reg   <= index_reg + AW'(1);
                                left_reg    <= left_reg - 6'h01;
                                state_reg   <= sibacc_pkg::SIBACC_TXB;
                            end
                        end
                    end
                    sibacc_pkg::SIBACC_IGNORE,
                    sibacc_pkg::SIBACC_IDLE:
                    begin
                        tx_mode_reg <= 1'b0;
                    end
                    default:
                        state_reg <= sibacc_pkg::SIBACC_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain data pin, output enable active low
    logic pull_low;
    assign pull_low = drive_low_reg | (tx_mode_reg && state_reg == sibacc_pkg::SIBACC_TXB && !tx_bit_reg);

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            SMB_DAT_O    <= 1'b1;
            SMB_DAT_OE_N <= 1'b1;
        end
        else
        begin
            SMB_DAT_O    <= 1'b0;
            SMB_DAT_OE_N <= ~pull_low;
        end
    end
endmodule // sibacc_slave
`default_nettype wire

// file: test/sibacc_slave_asserts.sv
// assertion checker for the indexed block access slave pins
`timescale 1ns/10ps
`default_nettype none
module sibacc_slave_asserts #(
    parameter logic [7:0] ADDR_W = 8'hD2
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SMB_CLK_I,
    input wire logic SMB_DAT_I,
    input wire logic SMB_DAT_O,
    input wire logic SMB_DAT_OE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    logic       scl_reg;
    logic       sda_reg;
    logic       in_addr_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] addr_sh_reg;
    wire        start_seen = SMB_CLK_I && scl_reg && sda_reg && !SMB_DAT_I;
    wire        stop_seen  = SMB_CLK_I && scl_reg && !sda_reg && SMB_DAT_I;
    wire        addr_end   = !SMB_CLK_I && scl_reg && in_addr_reg && bit_cnt_reg == 4'h8;
    wire        addr_hit   = addr_sh_reg[7:1] == ADDR_W[7:1];
    always_ff @(posedge CLK)
    begin
        scl_reg <= SMB_CLK_I;
        sda_reg <= SMB_DAT_I;
    end
    // only the first byte after a start is tracked; enough to judge address decode
    always_ff @(posedge CLK)
    begin
        if (RST || start_seen)
        begin
            in_addr_reg <= !RST;
            bit_cnt_reg <= 4'h0;
        end
        else if (SMB_CLK_I && !scl_reg && in_addr_reg && bit_cnt_reg < 4'h8)
        begin
            addr_sh_reg <= {addr_sh_reg[6:0], SMB_DAT_I};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        else if (addr_end)
            in_addr_reg <= 1'b0;
    end
    ////////////////////////////////////////
    a_reset_release: assert property (disable iff (1'b0) RST |=> SMB_DAT_OE_N)
        else $error("data line driven after reset");
    a_addr_ack: assert property (addr_end && addr_hit |-> ##[1:6] !SMB_DAT_OE_N)
        else $error("own address not acknowledged");
    a_addr_refuse: assert property (addr_end && !addr_hit |-> SMB_DAT_OE_N [*8])
        else $error("foreign address acknowledged");
    a_change_scl_low: assert property ($changed(SMB_DAT_OE_N) |-> !SMB_CLK_I)
        else $error("data drive changed while clock high");
    a_drive_after_fall: assert property ($fell(SMB_DAT_OE_N) |-> $past(SMB_CLK_I, 2) == 1'b0)
        else $error("drive began without a clock fall");
    a_stop_release: assert property (stop_seen |-> SMB_DAT_OE_N [*8])
        else $error("data line driven after stop");
    a_drive_bounded: assert property ($fell(SMB_DAT_OE_N) |-> ##[1:300] SMB_DAT_OE_N)
        else $error("data line held beyond one byte");
    a_drive_zero: assert property (!RST |=> !SMB_DAT_O)
        else $error("data output value not low");
    c_addr_ack: cover property (addr_end && addr_hit);
    c_addr_refuse: cover property (addr_end && !addr_hit);
    c_stop: cover property (stop_seen);
endmodule // sibacc_slave_asserts
bind sibacc_slave sibacc_slave_asserts #(.ADDR_W(ADDR_W)) sibacc_slave_asserts_inst (
    .CLK          (CLK),
    .RST          (RST),
    .SMB_CLK_I    (SMB_CLK_I),
    .SMB_DAT_I    (SMB_DAT_I),
    .SMB_DAT_O    (SMB_DAT_O),
    .SMB_DAT_OE_N (SMB_DAT_OE_N)
);
`default_nettype wire

// file: test/sibacc_host_model.sv
// behavioural smbus host driving clock and data pins
`timescale 1ns/10ps
`default_nettype none
module sibacc_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe_n
);
    // clock stands high outside frames; data released
    initial
    begin
        scl      = 1'b1;
        sda_oe_n = 1'b1;
    end
    ////////////////////////////////////////
    task automatic quarter();
        repeat (8) @(negedge clk);
    endtask
    // data moves only a quarter after the clock fall, stable while high
    task automatic bit_xfer(input logic b, output logic r);
        sda_oe_n = b;
        quarter();
        scl = 1'b1;
        quarter();
        r = sda;
        quarter();
        scl = 1'b0;
        quarter();
    endtask
    task automatic start();
        sda_oe_n = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sda_oe_n = 1'b0;
        quarter();
        scl = 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_oe_n = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sda_oe_n = 1'b1;
        quarter();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask
    // host acks all but the final byte, which it refuses
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
endmodule // sibacc_host_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the indexed block access slave
`timescale 1ns/10ps
`default_nettype none
`include "sibacc_map.svh"
module tb;
    logic       clk;
    logic       rst;
    logic       scl;
    logic       host_oe_n;
    logic       dat_o;
    logic       dat_oe_n;
    logic [7:0] exp_mem [16];
    int         err_total;
    int         comparisons;
    // open-drain line with pull-up
    wire        sda = host_oe_n && (dat_oe_n || dat_o);
    sibacc_slave sibacc_slave_inst (
        .CLK          (clk),
        .RST          (rst),
        .SMB_CLK_I    (scl),
        .SMB_DAT_I    (sda),
        .SMB_DAT_O    (dat_o),
        .SMB_DAT_OE_N (dat_oe_n)
    );
    sibacc_host_model sibacc_host_model_inst (
        .clk      (clk),
        .sda      (sda),
        .scl      (scl),
        .sda_oe_n (host_oe_n)
    );
    ////////////////////////////////////////
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic s);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic do_write(input logic [3:0] idx, input logic [7:0] d[$]);
        logic a;
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(`SIBACC_ADDR_W, a);
        chk_bit("write address ack", 1'b1, a);
        sibacc_host_model_inst.send_byte({4'h0, idx}, a);
        chk_bit("index ack", 1'b1, a);
        sibacc_host_model_inst.send_byte(8'(d.size()), a);
        chk_bit("count ack", 1'b1, a);
        foreach (d[k])
        begin
            sibacc_host_model_inst.send_byte(d[k], a);
            chk_bit("data ack", 1'b1, a);
            exp_mem[4'(idx + k)] = d[k];
        end
        sibacc_host_model_inst.stop();
    endtask
    task automatic do_read(input logic [3:0] idx);
        logic       a;
        logic [7:0] v;
        int         n;
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(`SIBACC_ADDR_W, a);
        chk_bit("write address ack", 1'b1, a);
        sibacc_host_model_inst.send_byte({4'h0, idx}, a);
        chk_bit("index ack", 1'b1, a);
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(`SIBACC_ADDR_R, a);
        chk_bit("read address ack", 1'b1, a);
        n = int'(exp_mem[`SIBACC_BC_IDX][5:0]);
        sibacc_host_model_inst.recv_byte(n == 0, v);
        chk_byte("count byte", exp_mem[`SIBACC_BC_IDX], v);
        for (int k = 0; k < n; k++)
        begin
            sibacc_host_model_inst.recv_byte(k == n - 1, v);
            chk_byte("read data", exp_mem[4'(idx + k)], v);
        end
        chk_bit("data line released", 1'b1, sda);
        sibacc_host_model_inst.stop();
    endtask
    ////////////////////////////////////////
    task automatic t_power_up();
        do_read(4'h4);
        $display("power-up read done");
    endtask
    task automatic t_wrap_write();
        do_write(4'hE, '{8'hA5, 8'h3C, 8'h96, 8'h0F});
        do_read(4'hE);
        $display("wrapping write done");
    endtask
    // upper two bits must not reach the count; zero count returns count byte only
    task automatic t_count_field();
        do_write(4'h6, '{8'hC3});
        do_read(4'hF);
        do_write(4'h6, '{8'h40});
        do_read(4'h2);
        $display("count field done");
    endtask
    // host acks past the count; the device must fall silent after the last counted byte
    task automatic t_count_limit();
        logic       a;
        logic [7:0] v;
        do_write(4'h6, '{8'h02});
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(`SIBACC_ADDR_W, a);
        chk_bit("write address ack", 1'b1, a);
        sibacc_host_model_inst.send_byte(8'h00, a);
        chk_bit("index ack", 1'b1, a);
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(`SIBACC_ADDR_R, a);
        chk_bit("read address ack", 1'b1, a);
        sibacc_host_model_inst.recv_byte(1'b0, v);
        chk_byte("count byte", 8'h02, v);
        for (int k = 0; k < 2; k++)
        begin
            sibacc_host_model_inst.recv_byte(1'b0, v);
            chk_byte("read data", exp_mem[k], v);
        end
        sibacc_host_model_inst.recv_byte(1'b1, v);
        chk_byte("byte past count", 8'hFF, v);
        sibacc_host_model_inst.stop();
        $display("count limit done");
    endtask
    task automatic t_refuse();
        logic a;
        sibacc_host_model_inst.start();
        sibacc_host_model_inst.send_byte(8'hA0, a);
        chk_bit("foreign address ack", 1'b0, a);
        sibacc_host_model_inst.send_byte(8'h00, a);
        chk_bit("ignored byte ack", 1'b0, a);
        sibacc_host_model_inst.stop();
        $display("foreign address done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        rst         = 1'b1;
        err_total   = 0;
        comparisons = 0;
        foreach (exp_mem[i])
            exp_mem[i] = `SIBACC_CFG_RESET;
        exp_mem[`SIBACC_BC_IDX] = `SIBACC_BC_RESET;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_power_up();
        t_refuse();
        t_wrap_write();
        t_count_field();
        t_count_limit();
        report_and_stop();
    end
    // about 63 bytes at 1.44 us each; generous margin
    initial
    begin
        #400_000;
        err_total++;
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
